// ===== shared/hpm_pkg.sv
/*
  Shared constants and types for the host port pin function multiplexer.
  Assumes a single clock domain and pins that are sampled synchronously.
*/
package hpm_pkg;

  // ----------------------------------------------------------------
  // Port geometry
  // ----------------------------------------------------------------
  localparam int unsigned PORT_W    = 32;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned WDATA_W   = 16;
  localparam int unsigned FSEL_W    = 4;

  // ----------------------------------------------------------------
  // Pin positions within the port
  // ----------------------------------------------------------------
  localparam int unsigned DATA0_SELECT_WIDTH_SHARED = 0;
  localparam int unsigned DATA1_CLOCK_READ_SHARED   = 1;
  localparam int unsigned DATA2_SIO_WRITE_SHARED    = 2;
  localparam int unsigned DATA3_READBACK_SHARED     = 3;
  localparam int unsigned DATA4_RESYNC_SHARED       = 4;
  localparam int unsigned DATA8_ADDR0_SHARED        = 8;
  localparam int unsigned DATA15_ADDR7_SHARED       = 15;
  localparam int unsigned PAR_DATA_LSB              = 16;
  localparam int unsigned PAR_DATA_MSB_NARROW       = 23;
  localparam int unsigned PAR_DATA_MSB_WIDE         = 31;

  // ----------------------------------------------------------------
  // Function select codes and keying bit positions
  // ----------------------------------------------------------------
  localparam logic [3:0] FSEL_SERIAL   = 4'h0;
  localparam logic [3:0] FSEL_PARALLEL = 4'h1;
  localparam int unsigned KEY_FREQUENCY = 0;
  localparam int unsigned KEY_PHASE     = 1;
  localparam int unsigned KEY_AMPLITUDE = 2;
  localparam logic [2:0] KEY_NONE         = 3'h0;
  localparam logic [2:0] KEY_FREQ_DEFAULT = 3'h1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] PORT_ZERO    = 32'h0000_0000;
  localparam logic [31:0] PORT_RELEASE = 32'hFFFF_FFFF;

  typedef enum logic [1:0] {
    HPM_SERIAL   = 2'b00,
    HPM_PARALLEL = 2'b01,
    HPM_MODULATE = 2'b11
  } hpm_mode_t;

  typedef struct packed {
    hpm_mode_t          mode;
    logic [2:0]         keying;
    logic               write_level;
    logic               par_write;
    logic               par_read;
    logic               par_wide;
    logic [ADDR_W-1:0]  par_addr;
    logic [WDATA_W-1:0] par_wdata;
    logic [PORT_W-1:0]  mod_data;
    logic               mod_valid;
    logic               ser_clock;
    logic               ser_select;
    logic               ser_resync;
    logic               ser_data_in;
    logic [PORT_W-1:0]  port_out;
    logic [PORT_W-1:0]  port_oe_n;
  } hpm_state_t;

  localparam hpm_state_t STATE_RESET = '{
    mode:        HPM_SERIAL,
    keying:      KEY_NONE,
    write_level: 1'b0,
    par_write:   1'b0,
    par_read:    1'b0,
    par_wide:    1'b0,
    par_addr:    8'h00,
    par_wdata:   16'h0000,
    mod_data:    PORT_ZERO,
    mod_valid:   1'b0,
    ser_clock:   1'b0,
    ser_select:  1'b0,
    ser_resync:  1'b0,
    ser_data_in: 1'b0,
    port_out:    PORT_ZERO,
    port_oe_n:   PORT_RELEASE
  };

endpackage : hpm_pkg

// ===== logic/hpm_mode_decode.sv
/*
  Decoder from the function select pins to port use and keying set.
  Assumes select levels are already synchronous to the clock.
*/
`timescale 1ns/100ps

module hpm_mode_decode (
  input  wire logic [3:0]       port_function_select,
  output hpm_pkg::hpm_mode_t    mode,
  output logic [2:0]            keying
);

  // ----------------------------------------------------------------
  // Select code to use
  // ----------------------------------------------------------------
  function automatic hpm_pkg::hpm_mode_t decode_mode(input logic [3:0] code);
    if (code == hpm_pkg::FSEL_SERIAL) begin
      decode_mode = hpm_pkg::HPM_SERIAL;
    end else if (code == hpm_pkg::FSEL_PARALLEL) begin
      decode_mode = hpm_pkg::HPM_PARALLEL;
    end else begin
      decode_mode = hpm_pkg::HPM_MODULATE;
    end
  endfunction : decode_mode

  always_comb begin
    mode   = decode_mode(port_function_select);
    keying = hpm_pkg::KEY_NONE;
    if (mode == hpm_pkg::HPM_MODULATE) begin
      keying = (port_function_select[2:0] == hpm_pkg::KEY_NONE) ?
               hpm_pkg::KEY_FREQ_DEFAULT : port_function_select[2:0];
    end
  end

endmodule : hpm_mode_decode

// ===== logic/hpm_pin_mux.sv
/*
  Host port pin function multiplexer: steers the 32-bit port between
  serial programming, parallel programming and direct modulation data.
  Assumes pins are synchronous to REF_CLK; the serial engine and the
  register file sit inside the device and connect through the SER_ and
  PAR_ ports. Output enables are active low (low = device drives).
*/
`timescale 1ns/100ps

module hpm_pin_mux (
  input  wire logic               REF_CLK,
  input  wire logic               RSTN,
  input  wire logic [3:0]         PORT_FUNCTION_SELECT,
  input  wire logic [31:0]        PORT_IN,
  output logic [31:0]             PORT_OUT,
  output logic [31:0]             PORT_OE_N,
  output hpm_pkg::hpm_mode_t      MODE,
  output logic [2:0]              KEYING,
  output logic [31:0]             MOD_DATA,
  output logic                    MOD_VALID,
  output logic [7:0]              PAR_ADDR,
  output logic [15:0]             PAR_WDATA,
  output logic                    PAR_WIDE,
  output logic                    PAR_WRITE,
  output logic                    PAR_READ,
  input  wire logic [15:0]        PAR_RDATA,
  output logic                    SER_CLOCK,
  output logic                    SER_SELECT,
  output logic                    SER_RESYNC,
  output logic                    SER_DATA_IN,
  input  wire logic               SER_SIO_OUT,
  input  wire logic               SER_SIO_DRIVE,
  input  wire logic               SER_READBACK_OUT,
  input  wire logic               SER_READBACK_DRIVE
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  hpm_pkg::hpm_state_t state;
  hpm_pkg::hpm_state_t next_state;
  hpm_pkg::hpm_mode_t  dec_mode;
  logic [2:0]          dec_keying;

  hpm_mode_decode u_decode (
    .port_function_select (PORT_FUNCTION_SELECT),
    .mode                 (dec_mode),
    .keying               (dec_keying)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state           = state;
    next_state.mode      = dec_mode;
    next_state.keying    = dec_keying;
    next_state.write_level = PORT_IN[hpm_pkg::DATA2_SIO_WRITE_SHARED];
    next_state.par_write = 1'b0;
    next_state.par_read  = 1'b0;
    next_state.mod_valid = 1'b0;
    next_state.ser_clock = 1'b0;
    next_state.ser_select = 1'b0;
    next_state.ser_resync = 1'b0;
    next_state.ser_data_in = 1'b0;
    next_state.port_out  = hpm_pkg::PORT_ZERO;
    next_state.port_oe_n = hpm_pkg::PORT_RELEASE;
    case (dec_mode)
      hpm_pkg::HPM_SERIAL: begin
        next_state.ser_clock  = PORT_IN[hpm_pkg::DATA1_CLOCK_READ_SHARED];
        next_state.ser_select = PORT_IN[hpm_pkg::DATA0_SELECT_WIDTH_SHARED];
        next_state.ser_resync = PORT_IN[hpm_pkg::DATA4_RESYNC_SHARED];
        next_state.ser_data_in = PORT_IN[hpm_pkg::DATA2_SIO_WRITE_SHARED];
        if (SER_SIO_DRIVE) begin
          next_state.port_out[hpm_pkg::DATA2_SIO_WRITE_SHARED]  = SER_SIO_OUT;
          next_state.port_oe_n[hpm_pkg::DATA2_SIO_WRITE_SHARED] = 1'b0;
        end
        if (SER_READBACK_DRIVE) begin
          next_state.port_out[hpm_pkg::DATA3_READBACK_SHARED]  = SER_READBACK_OUT;
          next_state.port_oe_n[hpm_pkg::DATA3_READBACK_SHARED] = 1'b0;
        end
      end
      hpm_pkg::HPM_PARALLEL: begin
        next_state.par_wide = PORT_IN[hpm_pkg::DATA0_SELECT_WIDTH_SHARED];
        if (PORT_IN[hpm_pkg::DATA2_SIO_WRITE_SHARED] && !state.write_level) begin
          next_state.par_write = 1'b1;
          next_state.par_addr  = PORT_IN[hpm_pkg::DATA15_ADDR7_SHARED:
                                         hpm_pkg::DATA8_ADDR0_SHARED];
          next_state.par_wdata = PORT_IN[hpm_pkg::PAR_DATA_MSB_WIDE:
                                         hpm_pkg::PAR_DATA_LSB];
          if (!next_state.par_wide) begin
            next_state.par_wdata[15:8] = 8'h00;
          end
        end
        if (PORT_IN[hpm_pkg::DATA1_CLOCK_READ_SHARED]) begin
          next_state.par_read = 1'b1;
          next_state.par_addr = PORT_IN[hpm_pkg::DATA15_ADDR7_SHARED:
                                        hpm_pkg::DATA8_ADDR0_SHARED];
          next_state.port_out[31:16]  = PAR_RDATA;
          next_state.port_oe_n[23:16] = 8'h00;
          if (next_state.par_wide) begin
            next_state.port_oe_n[31:24] = 8'h00;
          end else begin
            next_state.port_out[31:24] = 8'h00;
          end
        end
      end
      default: begin
        next_state.mod_data  = PORT_IN;
        next_state.mod_valid = 1'b1;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= hpm_pkg::STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign PORT_OUT    = state.port_out;
  assign PORT_OE_N   = state.port_oe_n;
  assign MODE        = state.mode;
  assign KEYING      = state.keying;
  assign MOD_DATA    = state.mod_data;
  assign MOD_VALID   = state.mod_valid;
  assign PAR_ADDR    = state.par_addr;
  assign PAR_WDATA   = state.par_wdata;
  assign PAR_WIDE    = state.par_wide;
  assign PAR_WRITE   = state.par_write;
  assign PAR_READ    = state.par_read;
  assign SER_CLOCK   = state.ser_clock;
  assign SER_SELECT  = state.ser_select;
  assign SER_RESYNC  = state.ser_resync;
  assign SER_DATA_IN = state.ser_data_in;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_select_mode;
    @(posedge REF_CLK) disable iff (!RSTN)
    (PORT_FUNCTION_SELECT == hpm_pkg::FSEL_PARALLEL) |=> (MODE == hpm_pkg::HPM_PARALLEL);
  endproperty
  a_select_mode: assert property (p_select_mode) else $error("Parallel select not seen");

  property p_mod_data;
    @(posedge REF_CLK) disable iff (!RSTN)
    MOD_VALID |-> (MOD_DATA == $past(PORT_IN)) && !PAR_WRITE && !PAR_READ && !SER_SELECT;
  endproperty
  a_mod_data: assert property (p_mod_data) else $error("Modulation word wrong");

  property p_write_addr;
    @(posedge REF_CLK) disable iff (!RSTN)
    PAR_WRITE |-> (PAR_ADDR == $past(PORT_IN[15:8])) && (MODE == hpm_pkg::HPM_PARALLEL);
  endproperty
  a_write_addr: assert property (p_write_addr) else $error("Write address wrong");

  property p_resync;
    @(posedge REF_CLK) disable iff (!RSTN)
    (PORT_FUNCTION_SELECT == hpm_pkg::FSEL_SERIAL) && PORT_IN[4] |=> SER_RESYNC;
  endproperty
  a_resync: assert property (p_resync) else $error("Resync not passed");

  property p_readback;
    @(posedge REF_CLK) disable iff (!RSTN)
    (PORT_FUNCTION_SELECT == hpm_pkg::FSEL_SERIAL) && SER_READBACK_DRIVE
      |=> !PORT_OE_N[3] && (PORT_OUT[3] == $past(SER_READBACK_OUT));
  endproperty
  a_readback: assert property (p_readback) else $error("Readback pin not driven");

  property p_sio;
    @(posedge REF_CLK) disable iff (!RSTN)
    (PORT_FUNCTION_SELECT == hpm_pkg::FSEL_SERIAL) && !SER_SIO_DRIVE |=> PORT_OE_N[2];
  endproperty
  a_sio: assert property (p_sio) else $error("Serial data line driven wrongly");

  property p_write_pulse;
    @(posedge REF_CLK) disable iff (!RSTN)
    (MODE == hpm_pkg::HPM_PARALLEL) && !PORT_IN[2] ##1
      (PORT_FUNCTION_SELECT == hpm_pkg::FSEL_PARALLEL) && PORT_IN[2] |=> PAR_WRITE ##1 !PAR_WRITE;
  endproperty
  a_write_pulse: assert property (p_write_pulse) else $error("Write strobe missed");

  property p_read;
    @(posedge REF_CLK) disable iff (!RSTN)
    PAR_READ |-> (PORT_OE_N[23:16] == 8'h00) && (PORT_OE_N[31:24] == {8{!PAR_WIDE}});
  endproperty
  a_read: assert property (p_read) else $error("Read drive width wrong");

  property p_width;
    @(posedge REF_CLK) disable iff (!RSTN)
    (PORT_FUNCTION_SELECT == hpm_pkg::FSEL_PARALLEL) |=> (PAR_WIDE == $past(PORT_IN[0]));
  endproperty
  a_width: assert property (p_width) else $error("Width select wrong");

  property p_no_drive;
    @(posedge REF_CLK) disable iff (!RSTN)
    (MODE == hpm_pkg::HPM_MODULATE) || ((MODE == hpm_pkg::HPM_PARALLEL) && !PAR_READ)
      |-> (PORT_OE_N == 32'hFFFF_FFFF);
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("Port driven outside a read");

endmodule : hpm_pin_mux

// ===== dv/hpm_host_model.sv
/*
  Host controller model driving the multipurpose port and select pins.
  Assumes tasks are called from the bench; pins change just after edges.
*/
`timescale 1ns/100ps

module hpm_host_model (
  input  wire logic        ref_clk,
  input  wire logic [31:0] port_out,
  input  wire logic [31:0] port_oe_n,
  output logic [31:0]      port_in,
  output logic [3:0]       fsel
);
  logic [31:0] pins;
  logic [31:0] held;

  initial begin
    pins = 32'h0000_0000;
    held = 32'hFFFF_FFFF;
    fsel = 4'h0;
  end

  // Device where it drives, host where it holds, else inverse of last value
  assign port_in = (~port_oe_n & port_out) | (port_oe_n & held & pins)
                 | (port_oe_n & ~held & ~pins);

  // Strobes, serial clock and width level are host-driven pins
  task drive(input logic [3:0] sel, input logic [31:0] value,
             input logic [31:0] mask);
    @(posedge ref_clk);
    fsel <= sel;
    pins <= value;
    held <= mask;
  endtask : drive
endmodule : hpm_host_model

// ===== dv/tb_hpm_pin_mux.sv
/*
  Self-checking bench for the host port pin multiplexer.
  Assumes the host model above and the design's one-cycle latency.
*/
`timescale 1ns/100ps

module tb_hpm_pin_mux;
  logic               ref_clk;
  logic               rstn;
  logic [31:0]        port_in;
  logic [31:0]        port_out;
  logic [31:0]        port_oe_n;
  logic [3:0]         fsel;
  hpm_pkg::hpm_mode_t mode;
  logic [2:0]         keying;
  logic [31:0]        mod_data;
  logic               mod_valid;
  logic [7:0]         par_addr;
  logic [15:0]        par_wdata;
  logic               par_wide;
  logic               par_write;
  logic               par_read;
  logic [15:0]        par_rdata;
  logic               ser_clock;
  logic               ser_select;
  logic               ser_resync;
  logic               ser_data_in;
  logic               sio_out;
  logic               sio_drive;
  logic               rb_out;
  logic               rb_drive;
  int                 num_errors;
  int                 num_checks;

  hpm_host_model u_hpm_host_model (.ref_clk(ref_clk), .port_out(port_out),
    .port_oe_n(port_oe_n), .port_in(port_in), .fsel(fsel));

  hpm_pin_mux u_hpm_pin_mux (.REF_CLK(ref_clk), .RSTN(rstn),
    .PORT_FUNCTION_SELECT(fsel), .PORT_IN(port_in), .PORT_OUT(port_out),
    .PORT_OE_N(port_oe_n), .MODE(mode), .KEYING(keying), .MOD_DATA(mod_data),
    .MOD_VALID(mod_valid), .PAR_ADDR(par_addr), .PAR_WDATA(par_wdata),
    .PAR_WIDE(par_wide), .PAR_WRITE(par_write), .PAR_READ(par_read),
    .PAR_RDATA(par_rdata), .SER_CLOCK(ser_clock), .SER_SELECT(ser_select),
    .SER_RESYNC(ser_resync), .SER_DATA_IN(ser_data_in), .SER_SIO_OUT(sio_out),
    .SER_SIO_DRIVE(sio_drive), .SER_READBACK_OUT(rb_out),
    .SER_READBACK_DRIVE(rb_drive));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task settle;
    @(posedge ref_clk);
    #1;
  endtask : settle

  task results;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_modulate;
    logic [2:0] k;
    for (int c = 2; c < 16; c++) begin
      u_hpm_host_model.drive(4'(c), 32'h1234_5678 ^ c, 32'hFFFF_FFFF);
      settle;
      k = (c[2:0] == 3'h0) ? hpm_pkg::KEY_FREQ_DEFAULT : c[2:0];
      chk("mode", {30'h0, hpm_pkg::HPM_MODULATE}, {30'h0, mode});
      chk("keying", {29'h0, k}, {29'h0, keying});
      chk("mod_data", 32'h1234_5678 ^ c, mod_data);
      chk("mod_valid", 32'h1, {31'h0, mod_valid});
      chk("oe_n", 32'hFFFF_FFFF, port_oe_n);
      chk("strobes", 32'h0, {26'h0, par_write, par_read, ser_clock,
          ser_select, ser_resync, ser_data_in});
    end
    $display("test modulate done");
  endtask : t_modulate

  task t_write(input logic wide, input logic [7:0] a, input logic [15:0] d);
    u_hpm_host_model.drive(4'h1, {d, a, 7'h00, wide}, 32'hFFFF_FFFF);
    u_hpm_host_model.drive(4'h1, {d, a, 7'h02, wide}, 32'hFFFF_FFFF);
    settle;
    chk("par_write", 32'h1, {31'h0, par_write});
    chk("par_addr", {24'h0, a}, {24'h0, par_addr});
    chk("par_wdata", {16'h0, wide ? d : {8'h00, d[7:0]}}, {16'h0, par_wdata});
    chk("par_wide", {31'h0, wide}, {31'h0, par_wide});
    chk("mode", {30'h0, hpm_pkg::HPM_PARALLEL}, {30'h0, mode});
    chk("keying", 32'h0, {29'h0, keying});
    chk("mod_valid", 32'h0, {31'h0, mod_valid});
    chk("oe_n", 32'hFFFF_FFFF, port_oe_n);
    settle;
    chk("par_write", 32'h0, {31'h0, par_write});
    $display("test write done");
  endtask : t_write

  task t_read(input logic wide);
    @(posedge ref_clk) par_rdata <= 16'hBEEF;
    u_hpm_host_model.drive(4'h1, {16'h0, 8'h3C, 7'h01, wide}, 32'h0000_FFFF);
    settle;
    chk("par_read", 32'h1, {31'h0, par_read});
    chk("par_addr", 32'h3C, {24'h0, par_addr});
    chk("oe_n", wide ? 32'h0000_FFFF : 32'hFF00_FFFF, port_oe_n);
    chk("pins", wide ? 32'hBEEF_0000 : 32'h00EF_0000, port_in & ~port_oe_n);
    u_hpm_host_model.drive(4'h1, {16'h0, 8'h3C, 7'h00, wide}, 32'hFFFF_FFFF);
    settle;
    chk("par_read", 32'h0, {31'h0, par_read});
    chk("oe_n", 32'hFFFF_FFFF, port_oe_n);
    $display("test read done");
  endtask : t_read

  task t_serial;
    @(posedge ref_clk) rb_drive <= 1'b1;
    rb_out <= 1'b1;
    u_hpm_host_model.drive(4'h0, 32'h0000_0011, 32'hFFFF_FFFF);
    settle;
    chk("mode", {30'h0, hpm_pkg::HPM_SERIAL}, {30'h0, mode});
    chk("ser_pins", 32'h6, {28'h0, ser_clock, ser_select, ser_resync,
        ser_data_in});
    chk("oe_n", 32'hFFFF_FFF7, port_oe_n);
    chk("readback", 32'h8, port_out & 32'h8);
    @(posedge ref_clk) rb_drive <= 1'b0;
    sio_drive <= 1'b1;
    sio_out <= 1'b1;
    u_hpm_host_model.drive(4'h0, 32'h0000_0005, 32'hFFFF_FFFB);
    settle;
    chk("oe_n", 32'hFFFF_FFFB, port_oe_n);
    chk("sio", 32'h4, port_in & 32'h4);
    chk("ser_pins", 32'h5, {28'h0, ser_clock, ser_select, ser_resync,
        ser_data_in});
    @(posedge ref_clk) sio_drive <= 1'b0;
    settle;
    settle;
    chk("oe_n", 32'hFFFF_FFFF, port_oe_n);
    $display("test serial done");
  endtask : t_serial

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    #24000;
    num_errors++;
    results;
  end

  initial begin
    num_errors = 0;
    num_checks = 0;
    rstn = 1'b0;
    par_rdata = 16'h0000;
    sio_out = 1'b0;
    sio_drive = 1'b0;
    rb_out = 1'b0;
    rb_drive = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    chk("oe_n", 32'hFFFF_FFFF, port_oe_n);
    chk("mode", {30'h0, hpm_pkg::HPM_SERIAL}, {30'h0, mode});
    @(posedge ref_clk) rstn <= 1'b1;
    t_modulate;
    t_write(1'b0, 8'hA5, 16'hABCD);
    t_write(1'b1, 8'h5A, 16'h1357);
    t_read(1'b0);
    t_read(1'b1);
    t_serial;
    results;
  end
endmodule : tb_hpm_pin_mux
